/* dv/ict_checker.sv */
// Port-level timing checks for the cycle timer
`timescale 1ns/10ps
module ict_checker
  import ict_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic ISSUE,
  input wire logic [3:0] ICLASS,
  input wire logic COND_TRUE,
  input wire logic ODD_START,
  input wire logic [1:0] AMODE,
  input wire logic [7:0] WAIT_STATES,
  input wire logic [7:0] FETCH_TERM,
  input wire logic BUSY,
  input wire logic DONE,
  input wire logic POWER_DOWN,
  input wire logic [7:0] LAST_STATES
);
  logic [9:0] cnt_r;
  logic take;
  logic bcc;
  // Busy cycles of the running instruction
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_r <= 10'h000;
    end else begin
      cnt_r <= BUSY ? cnt_r + 10'h001 : 10'h000;
    end
  end
  // Fixed counts only hold without waits or fetch extras
  assign take = ISSUE && !BUSY && WAIT_STATES == 8'h00 && FETCH_TERM == 8'h00;
  assign bcc = take && ICLASS == ICT_CLS_BCC;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////
  sequence s_end3;
    ##13 DONE;
  endsequence
  sequence s_end2;
    ##9 DONE;
  endsequence
  AST_ISSUE_BUSY: assert property (ISSUE && !BUSY |=> BUSY)
    else $error("issue did not raise busy");
  AST_DONE_PULSE: assert property (DONE |=> !DONE)
    else $error("done longer than one cycle");
  AST_BUSY_END: assert property ($fell(BUSY) |-> DONE)
    else $error("busy fell without done");
  AST_STATE_LEN: assert property (
    DONE |-> cnt_r == {LAST_STATES, 2'h0})
    else $error("busy span differs from four clocks per state");
  AST_MIN_LEN: assert property ($rose(BUSY) |-> BUSY [*8])
    else $error("instruction shorter than two states");
  AST_BCC_FALL: assert property (bcc && !COND_TRUE |-> s_end3)
    else $error("untaken branch not three states");
  AST_BCC_ODD: assert property (
    bcc && COND_TRUE && ODD_START |=> LAST_STATES == 8'h08)
    else $error("taken odd branch total wrong");
  AST_SLEEP_LEN: assert property (
    take && ICLASS == ICT_CLS_SLEEP && AMODE == 2'h0 |-> s_end2)
    else $error("sleep not two states");
  AST_PD_CLEAR: assert property (POWER_DOWN && ISSUE && !BUSY |=> !POWER_DOWN)
    else $error("power down kept after new issue");
endmodule
////////////////////////////////////////
bind ict_top ict_checker ict_checker_inst (
  .CLK(CLK), .RST_N(RST_N), .ISSUE(ISSUE), .ICLASS(ICLASS),
  .COND_TRUE(COND_TRUE), .ODD_START(ODD_START), .AMODE(AMODE),
  .WAIT_STATES(WAIT_STATES), .FETCH_TERM(FETCH_TERM), .BUSY(BUSY),
  .DONE(DONE), .POWER_DOWN(POWER_DOWN), .LAST_STATES(LAST_STATES)
);

/* dv/ict_peri_model.sv */
// Slow peripheral clock model facing the cycle timer
`timescale 1ns/10ps
module ict_peri_model (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic STALL,
  output logic PERI_EDGE
);
  logic [4:0] div_r;
  // Free divider, high half of a 32 cycle period
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      div_r <= 5'h00;
    end else begin
      div_r <= div_r + 5'h01;
    end
  end
  // Stall stands for a peripheral clock that never lines up in time
  assign PERI_EDGE = div_r[4] && !STALL;
endmodule

/* dv/test_instruction_cycle_timing.sv */
// Self-checking bench for the instruction cycle timer
`timescale 1ns/10ps
module test_instruction_cycle_timing;
  import ict_pkg::*;
  typedef struct packed {
    ict_class_type c;
    logic [1:0] m;
    logic o, x, t, n, v;
    logic [3:0] r;
    logic [7:0] b, w, f;
    logic h;
    logic [7:0] e;
  } ict_row_type;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic issue = 1'h0;
  logic stall = 1'h0;
  logic peri_edge, busy, done, pwr_dn;
  logic [7:0] last;
  ict_row_type cur = '0;
  int fail_count = 0;
  int n_tests = 0;
  int cyc;
  // Class,mode,odd,max,cond,minus1,ovf,regs,base,wait,fetch,halve,states
  ict_row_type rows [21] = '{
    '{ICT_CLS_BCC,0,0,0,1,0,0,0,0,0,0,0,7},
    '{ICT_CLS_BCC,0,1,0,1,0,0,0,0,0,0,0,8},
    '{ICT_CLS_BCC,0,1,0,0,0,0,0,0,0,0,0,3},
    '{ICT_CLS_SCB,0,0,0,0,0,0,0,0,0,0,0,3},
    '{ICT_CLS_SCB,0,0,0,1,1,0,0,0,0,0,0,4},
    '{ICT_CLS_SCB,0,1,0,1,0,0,0,0,0,0,0,9},
    '{ICT_CLS_TRAPV,0,0,0,0,0,1,0,0,0,0,0,18},
    '{ICT_CLS_TRAPV,0,1,1,0,0,1,0,0,0,0,0,24},
    '{ICT_CLS_TRAPV,0,1,0,0,0,0,0,0,0,0,0,3},
    '{ICT_CLS_DIVZ,0,0,0,0,0,0,0,0,0,0,0,20},
    '{ICT_CLS_DIVZ,0,0,1,0,0,0,0,0,0,0,0,25},
    '{ICT_CLS_LDM,0,0,0,0,0,0,15,0,0,0,0,66},
    '{ICT_CLS_STM,0,0,0,0,0,0,5,0,0,0,0,21},
    '{ICT_CLS_SLEEP,0,0,0,0,0,0,0,0,0,0,0,2},
    '{ICT_CLS_FLOW,0,1,0,0,0,0,0,9,0,0,0,10},
    '{ICT_CLS_IMM16,1,0,0,0,0,0,0,8,0,0,0,10},
    '{ICT_CLS_IMM16,2,1,0,0,0,0,0,8,0,0,0,10},
    '{ICT_CLS_PLAIN,1,0,0,0,0,0,0,5,0,0,0,6},
    '{ICT_CLS_PLAIN,2,1,0,0,0,0,0,5,0,0,0,6},
    '{ICT_CLS_PLAIN,1,1,0,0,0,0,0,5,3,0,0,8},
    '{ICT_CLS_PLAIN,1,0,0,0,0,0,0,5,0,3,1,7}
  };
  ict_top ict_top_inst (
    .CLK(clk), .RST_N(rst_n), .ISSUE(issue), .ICLASS(cur.c), .AMODE(cur.m),
    .ODD_START(cur.o), .MAX_MODE(cur.x), .COND_TRUE(cur.t),
    .COUNT_MINUS1(cur.n), .OVF_FLAG(cur.v), .REG_COUNT(cur.r),
    .TABLE_BASE(cur.b), .WAIT_STATES(cur.w), .FETCH_TERM(cur.f),
    .FETCH_HALVE(cur.h), .PERI_EDGE(peri_edge), .BUSY(busy), .DONE(done),
    .POWER_DOWN(pwr_dn), .LAST_STATES(last)
  );
  ict_peri_model ict_peri_model_inst (
    .CLK(clk), .RST_N(rst_n), .STALL(stall), .PERI_EDGE(peri_edge)
  );
  always #12.5 clk = ~clk;
  ////////////////////////////////////////
  task automatic chk(input logic [9:0] g, input logic [9:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Bounded, so a stuck sequencer shows up as a count mismatch
  task automatic wt();
    while (done !== 1'h1 && cyc < 999) begin
      @(negedge clk);
      cyc++;
    end
  endtask
  task automatic go(input ict_row_type r);
    @(negedge clk);
    cur = r;
    issue = 1'h1;
    @(negedge clk);
    issue = 1'h0;
    cyc = 0;
    wt();
  endtask
  task automatic end_of_test();
    if (fail_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run of about 1400 cycles
  initial begin
    #150000;
    fail_count++;
    end_of_test();
  end
  initial begin
    repeat (6) @(negedge clk);
    chk({busy | done | pwr_dn, 1'h0, last}, 10'h000);
    rst_n = 1'h1;
    foreach (rows[i]) begin
      go(rows[i]);
      chk(10'(cyc), 10'(4 * rows[i].e));
      chk({2'h0, last}, {2'h0, rows[i].e});
    end
    // Held request: second class refused while busy, taken on the edge after done
    @(negedge clk);
    cur = rows[0];
    issue = 1'h1;
    @(negedge clk);
    cyc = 0;
    cur.c = ICT_CLS_SLEEP;
    wt();
    chk(10'(cyc), 10'h01C);
    chk({2'h0, last}, 10'h007);
    chk({9'h000, pwr_dn}, 10'h000);
    @(negedge clk);
    issue = 1'h0;
    cyc = 0;
    wt();
    chk(10'(cyc), 10'h008);
    @(negedge clk);
    chk({9'h000, pwr_dn}, 10'h001);
    go(rows[17]);
    chk({9'h000, pwr_dn}, 10'h000);
    // Peripheral move: prompt clock, then one that never lines up
    for (int s = 0; s < 2; s++) begin
      stall = s[0];
      go('{ICT_CLS_PERI,1,1,0,0,0,0,0,0,0,0,0,0});
      chk(10'(cyc), {last, 2'h0});
      chk({9'h000, last >= 8'h0D && last <= 8'h14}, 10'h001);
      chk({9'h000, last == 8'h14 || !stall}, 10'h001);
    end
    // Reset in mid-run drops the sequence at once
    @(negedge clk);
    cur = rows[11];
    issue = 1'h1;
    repeat (20) @(negedge clk);
    issue = 1'h0;
    rst_n = 1'h0;
    #1;
    chk({8'h00, busy, done}, 10'h000);
    @(negedge clk);
    rst_n = 1'h1;
    go(rows[0]);
    chk(10'(cyc), 10'h01C);
    end_of_test();
  end
endmodule

/* include/ict_consts.svh */
// State counts and clock timing for the instruction cycle timer
`ifndef ICT_CONSTS_SVH
`define ICT_CONSTS_SVH
`define ICT_CLK_HZ 40000000
`define ICT_STATE_NS 100
`define ICT_CLK_NS 25
`define ICT_CYC_PER_STATE ((`ICT_STATE_NS + `ICT_CLK_NS - 1) / `ICT_CLK_NS)
`define ICT_BCC_TAKEN 8'h07
`define ICT_BCC_FALL 8'h03
`define ICT_SCB_FALSE 8'h03
`define ICT_SCB_MINUS1 8'h04
`define ICT_SCB_TAKEN 8'h08
`define ICT_TRAPV_MIN 8'h12
`define ICT_TRAPV_MAX 8'h17
`define ICT_TRAPV_NONE 8'h03
`define ICT_DIVZ_MIN 8'h14
`define ICT_DIVZ_MAX 8'h19
`define ICT_MULT_BASE 8'h06
`define ICT_LDM_PER 8'h04
`define ICT_STM_PER 8'h03
`define ICT_PERI_MIN 8'h0D
`define ICT_PERI_MAX 8'h14
`define ICT_SLEEP 8'h02
`define ICT_IMM16_ADJ 8'h02
`endif

/* include/ict_pkg.sv */
// Types for the instruction cycle timer
package ict_pkg;
  typedef enum logic [3:0] {
    ICT_CLS_PLAIN, ICT_CLS_BCC, ICT_CLS_SCB, ICT_CLS_TRAPV, ICT_CLS_DIVZ,
    ICT_CLS_LDM, ICT_CLS_STM, ICT_CLS_PERI, ICT_CLS_SLEEP, ICT_CLS_FLOW,
    ICT_CLS_IMM16
  } ict_class_type;
  // Addressing-mode groups as they affect the start adjustment
  typedef enum logic [1:0] {
    ICT_AM_REG, ICT_AM_LONG, ICT_AM_SHORT
  } ict_mode_type;
  typedef enum logic [1:0] {ICT_IDLE, ICT_RUN, ICT_PERI_WAIT} ict_state_type;
  typedef struct packed {
    ict_state_type st;
    logic [7:0] states_left;
    logic [1:0] sub;
    logic busy;
    logic done;
    logic power_down;
    logic [7:0] total;
    ict_class_type cls;
    logic [7:0] limit;
  } ict_seq_type;
endpackage

/* include/ict_req_if.sv */
// Decoded request from issue logic to the cost calculation
`timescale 1ns/10ps
interface ict_req_if;
  import ict_pkg::*;
  logic valid;
  ict_class_type cls;
  ict_mode_type mode;
  logic odd;
  logic [7:0] base;
  logic [7:0] extra;
  modport src (output valid, cls, mode, odd, base, extra);
  modport dst (input valid, cls, mode, odd, base, extra);
endinterface

/* logic/ict_cost.sv */
// Base state count plus start-address adjustment for one instruction
`timescale 1ns/10ps
`include "ict_consts.svh"
module ict_cost
  import ict_pkg::*;
(
  ict_req_if.dst req,
  output logic [7:0] total
);
  logic [7:0] adj;
  // Start adjustment depends on class, mode group and address parity
  always_comb begin
    adj = 8'h00;
    unique case (req.cls)
      ICT_CLS_FLOW:
        adj = {7'h00, req.odd}; // RQ9
      ICT_CLS_IMM16: begin
        if (req.mode == ICT_AM_LONG && !req.odd) begin
          adj = `ICT_IMM16_ADJ; // RQ10
        end else if (req.mode == ICT_AM_SHORT && req.odd) begin
          adj = `ICT_IMM16_ADJ; // RQ10
        end
      end
      default: begin
        if (req.mode == ICT_AM_LONG && !req.odd) begin
          adj = 8'h01; // RQ11
        end else if (req.mode == ICT_AM_SHORT && req.odd) begin
          adj = 8'h01; // RQ11
        end
      end
    endcase
  end
  // Sum of base (with fetch term folded in), wait states and adjustment
  assign total = req.base + req.extra + adj; // RQ13 RQ15
endmodule

/* logic/ict_top.sv */
// Instruction cycle timer: holds issue for each instruction's state count
`timescale 1ns/10ps
`include "ict_consts.svh"
// Functional notes
// [RQ1] Conditional branch: 7 states taken, 3 states not taken.
// [RQ2] Count-branch: 3 if false, 4 at count minus one, else 8.
// [RQ3] Overflow trap taken: 18 small mode, 23 large mode.
// [RQ4] Overflow clear: no trap, 3 states.
// [RQ5] Zero divide, register source: 20 small, 25 large mode.
// [RQ6] Load multiple 6+4n, store multiple 6+3n states.
// [RQ7] Peripheral moves align to slow clock, 13 to 20 states.
// [RQ8] Sleep spends 2 states then enters power-down.
// [RQ9] Flow-change instructions add one state at odd start.
// [RQ10] Immediate word store adds 2 by mode and parity.
// [RQ11] Other instructions add 1 by mode group and parity.
// [RQ12] One state equals one system clock period, 100 ns at 10 MHz.
// [RQ13] Slow-area wait and precharge states add to the count.
// [RQ14] Halved fetch term from 3-state 16-bit area rounds down.
// [RQ15] Total is base plus adjustment; next issue held until done.
module ict_top
  import ict_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic ISSUE,
  input wire logic [3:0] ICLASS,
  input wire logic [1:0] AMODE,
  input wire logic ODD_START,
  input wire logic MAX_MODE,
  input wire logic COND_TRUE,
  input wire logic COUNT_MINUS1,
  input wire logic OVF_FLAG,
  input wire logic [3:0] REG_COUNT,
  input wire logic [7:0] TABLE_BASE,
  input wire logic [7:0] WAIT_STATES,
  input wire logic [7:0] FETCH_TERM,
  input wire logic FETCH_HALVE,
  input wire logic PERI_EDGE,
  output logic BUSY,
  output logic DONE,
  output logic POWER_DOWN,
  output logic [7:0] LAST_STATES
);
  ict_req_if req ();
  ict_seq_type cur_r, cur_nxt;
  ict_class_type cls;
  logic [7:0] base;
  logic [7:0] total;
  logic [7:0] fetch;
  logic stretch;

  assign cls = ict_class_type'(ICLASS);
  // Fetch term halves with fractions dropped
  assign fetch = FETCH_HALVE ? {1'b0, FETCH_TERM[7:1]} : FETCH_TERM; // RQ14
  // Peripheral moves wait for the slow clock, bounded so that a dead
  // clock cannot hold issue forever
  assign stretch = cur_r.cls == ICT_CLS_PERI &&
                   cur_r.total < cur_r.limit && !PERI_EDGE; // RQ7

  ////////////////////////////////////////////////////////////////////////
  // Base state count per class and condition
  always_comb begin
    base = TABLE_BASE;
    unique case (cls)
      ICT_CLS_BCC: begin
        if (COND_TRUE) begin
          base = `ICT_BCC_TAKEN; // RQ1
        end else begin
          base = `ICT_BCC_FALL; // RQ1
        end
      end
      ICT_CLS_SCB: begin
        if (!COND_TRUE) begin
          base = `ICT_SCB_FALSE; // RQ2
        end else if (COUNT_MINUS1) begin
          base = `ICT_SCB_MINUS1; // RQ2
        end else begin
          base = `ICT_SCB_TAKEN; // RQ2
        end
      end
      ICT_CLS_TRAPV: begin
        if (!OVF_FLAG) begin
          base = `ICT_TRAPV_NONE; // RQ4
        end else if (MAX_MODE) begin
          base = `ICT_TRAPV_MAX; // RQ3
        end else begin
          base = `ICT_TRAPV_MIN; // RQ3
        end
      end
      ICT_CLS_DIVZ: begin
        if (MAX_MODE) begin
          base = `ICT_DIVZ_MAX; // RQ5
        end else begin
          base = `ICT_DIVZ_MIN; // RQ5
        end
      end
      // Register list count scales the multi-register transfers
      ICT_CLS_LDM: begin
        base = `ICT_MULT_BASE + 8'(REG_COUNT) * `ICT_LDM_PER; // RQ6
      end
      ICT_CLS_STM: begin
        base = `ICT_MULT_BASE + 8'(REG_COUNT) * `ICT_STM_PER; // RQ6
      end
      ICT_CLS_PERI: begin
        base = `ICT_PERI_MIN; // RQ7
      end
      ICT_CLS_SLEEP: begin
        base = `ICT_SLEEP; // RQ8
      end
      default: begin
        base = TABLE_BASE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Taken branches and taken overflow traps adjust like flow-change instructions
  always_comb begin
    req.cls = cls;
    if ((cls == ICT_CLS_BCC && COND_TRUE) ||
        (cls == ICT_CLS_SCB && COND_TRUE && !COUNT_MINUS1) ||
        (cls == ICT_CLS_TRAPV && OVF_FLAG)) begin
      req.cls = ICT_CLS_FLOW; // RQ9
    end else if (cls == ICT_CLS_BCC || cls == ICT_CLS_SCB ||
                 cls == ICT_CLS_TRAPV) begin
      req.cls = ICT_CLS_PLAIN;
    end
  end
  assign req.valid = ISSUE;
  // Register-only classes take no addressing adjustment
  assign req.mode = (cls == ICT_CLS_PLAIN || cls == ICT_CLS_IMM16 ||
                     cls == ICT_CLS_PERI) ?
                    ict_mode_type'(AMODE) : ICT_AM_REG;
  assign req.odd = ODD_START;
  assign req.base = base + fetch;
  assign req.extra = WAIT_STATES; // RQ13

  ict_cost u_cost (
    .req(req),
    .total(total)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: each state is a fixed number of clocks
  always_comb begin
    cur_nxt = cur_r;
    cur_nxt.done = 1'b0;
    unique case (cur_r.st)
      ICT_IDLE: begin
        if (ISSUE) begin // RQ15
          // Class latched so a refused request cannot alter the ending
          cur_nxt.cls = cls;
          cur_nxt.total = (total == 8'h00) ? 8'h01 : total;
          cur_nxt.limit = total + (`ICT_PERI_MAX - `ICT_PERI_MIN); // RQ7
          cur_nxt.states_left = (total == 8'h00) ? 8'h01 : total;
          cur_nxt.sub = 2'(`ICT_CYC_PER_STATE - 1);
          cur_nxt.busy = 1'b1;
          cur_nxt.power_down = 1'b0;
          cur_nxt.st = ICT_RUN;
        end
      end
      ICT_RUN: begin
        // Last clock of the last state decides: stretch or finish
        if (cur_r.sub != 2'h0) begin
          cur_nxt.sub = cur_r.sub - 2'h1; // RQ12
        end else if (cur_r.states_left != 8'h01) begin
          cur_nxt.states_left = cur_r.states_left - 8'h01;
          cur_nxt.sub = 2'(`ICT_CYC_PER_STATE - 1);
        end else if (stretch) begin
          // Stretch one state at a time until the slow clock aligns
          cur_nxt.total = cur_r.total + 8'h01; // RQ7
          cur_nxt.sub = 2'(`ICT_CYC_PER_STATE - 1);
          cur_nxt.st = ICT_PERI_WAIT;
        end else begin
          cur_nxt.busy = 1'b0; // RQ15
          cur_nxt.done = 1'b1;
          cur_nxt.power_down = (cur_r.cls == ICT_CLS_SLEEP); // RQ8
          cur_nxt.st = ICT_IDLE;
        end
      end
      ICT_PERI_WAIT: begin
        // Hand back one clock early: the check in the run state is the
        // last clock of the added state, so a stretch costs one state
        if (cur_r.sub > 2'h1) begin
          cur_nxt.sub = cur_r.sub - 2'h1; // RQ12
        end else begin
          cur_nxt.sub = 2'h0;
          cur_nxt.states_left = 8'h01;
          cur_nxt.st = ICT_RUN;
        end
      end
      default: begin
        cur_nxt.st = ICT_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cur_r <= '0;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs taken straight from the state register
  assign BUSY = cur_r.busy;
  assign DONE = cur_r.done;
  assign POWER_DOWN = cur_r.power_down;
  assign LAST_STATES = cur_r.total;
endmodule
